//--- hw/scp_pkg.sv
// package: register map, field layout, timing constants and carriers for the clock prescaler
package scp_pkg;

  // register byte offsets on the wishbone bus
  localparam logic [3:0] ADDR_TRIM = 4'h0; // oscillator_trim
  localparam logic [3:0] ADDR_DIV = 4'h4; // clock_divide_control
  localparam logic [3:0] ADDR_STAT = 4'h8; // status: applied code, settled flag, startup phase
  localparam logic [3:0] ADDR_FUSE = 4'hc; // read-only fuse view

  // field positions
  localparam int TRIM_MSB = 6; // trim_value occupies 6..0
  localparam int DIV_CE_BIT = 7; // divide_change_enable
  localparam int DIV_CODE_MSB = 3; // divide_code occupies 3..0

  // reset values and encodings
  localparam logic [6:0] TRIM_DEFAULT = 7'h40; // reset value; kept after boot only if no factory byte
  localparam logic [3:0] CODE_DIV1 = 4'h0; // divide by 1
  localparam logic [3:0] CODE_DIV8 = 4'h3; // divide by 8, taken at reset only when the divide-by-eight fuse is set
  localparam logic [3:0] CODE_MAX = 4'h8; // divide by 256, above is reserved
  localparam logic [3:0] CLOCK_SOURCE_SELECT_FUSES_EXT = 4'h0; // external clock on the input pin
  localparam logic [1:0] SUT_NONE = 2'h0;
  localparam logic [1:0] SUT_SHORT = 2'h1;
  localparam logic [1:0] SUT_LONG = 2'h2;

  // timing
  localparam int CLK_MHZ = 250; // ref_clk rate
  localparam int UNLOCK_CYCLES = 4; // change-enable life
  localparam int WAKE_CK = 6; // wake-up from power-down / power-save
  localparam int DELAY_SHORT_US = 4100; // 4.1 ms
  localparam int DELAY_LONG_US = 65000; // 65 ms
  localparam int DELAY_SHORT_CYC = DELAY_SHORT_US * CLK_MHZ;
  localparam int DELAY_LONG_CYC = DELAY_LONG_US * CLK_MHZ;

  // fuse straps travel together
  typedef struct packed {
    logic [3:0] clock_source_select_fuses;
    logic [1:0] startup_delay_fuses;
    logic clock_output_fuse;
    logic divide_by_eight_fuse;
  } scp_fuse_t;

  // clocks handed to the rest of the chip
  typedef struct packed {
    logic io_clk;
    logic cpu_clk;
    logic flash_clk;
    logic async_timer_clock;
  } scp_clocks_t;

endpackage

//--- hw/scp_divider.sv
// glitch-free power-of-two clock divider driven from the undivided clock
`timescale 1ns/10ps
`default_nettype none
module scp_divider #(
  parameter int CODE_W = 4,
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // control
  input wire logic [CODE_W-1:0] code_in,
  input wire logic [CODE_W-1:0] reset_code,
  // divided clock and status
  output logic clk_out,
  output logic [CODE_W-1:0] code_active,
  output logic settled
);

  // all state in one struct
  typedef struct packed {
    logic [CNT_W-1:0] cnt; // phase counter of the divided clock
    logic [CODE_W-1:0] code; // setting in effect
    logic clk; // divided clock, from a flop so no decode glitch
    logic boot; // first cycle after reset takes the fuse code
  } scp_div_state_t;

  scp_div_state_t s_r;
  scp_div_state_t s_nxt;

  // half period in ref_clk cycles, minus one; code 0 passes the clock through
  function automatic logic [CNT_W-1:0] half_len(input logic [CODE_W-1:0] c);
    logic [CNT_W:0] one;
    one = {{CNT_W{1'b0}}, 1'b1};
    half_len = (c == '0) ? '0 : CNT_W'((one << (c - 1'b1)) - 1'b1);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // next state: code changes only at a rising boundary of the divided clock
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.boot = 1'b0;
    if (s_r.boot)
    begin
      s_nxt.code = reset_code; // strap taken after release, not under reset
    end
    else if (s_r.code == '0)
    begin
      s_nxt.clk = 1'b1; // pass-through mode uses ref_clk directly
      s_nxt.code = code_in;
    end
    else if (s_r.cnt == half_len(s_r.code))
    begin
      s_nxt.cnt = '0;
      s_nxt.clk = ~s_r.clk;
      // swap only as the low half ends, so no period is shorter than both
      if (!s_r.clk)
      begin
        s_nxt.code = code_in; // new rate starts on the next full period
      end
    end
    else
    begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_r <= '{cnt: '0, code: '0, clk: 1'b1, boot: 1'b1};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // pass-through mode gates nothing; the mux select only moves at a rising point
  assign clk_out = (s_r.code == '0) ? ref_clk : s_r.clk;
  assign code_active = s_r.code;
  assign settled = (s_r.code == code_in);

endmodule
`default_nettype wire

//--- hw/scp_top.sv
// system clock prescaler, oscillator trim and clock output control with wishbone slave
`timescale 1ns/10ps
`default_nettype none
module scp_top #(
  parameter int SHORT_DELAY_CYC = scp_pkg::DELAY_SHORT_CYC,
  parameter int LONG_DELAY_CYC = scp_pkg::DELAY_LONG_CYC,
  parameter logic [6:0] FACTORY_TRIM = scp_pkg::TRIM_DEFAULT
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // clock sources
  input wire logic oscillator_input_pin,
  input wire logic rc_osc_clk,
  // straps and factory data
  input wire scp_pkg::scp_fuse_t fuses,
  input wire logic [6:0] factory_trim,
  input wire logic factory_trim_valid,
  // sleep and timer control
  input wire logic wake_req,
  input wire logic timer_sync_mode,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // clock outputs
  output scp_pkg::scp_clocks_t clocks,
  output logic [6:0] rc_trim,
  output logic ext_clk_sel,
  output logic irq_block,
  output logic cpu_run,
  // port b bit 0 as two signals
  output logic portb0_out,
  output logic portb0_oe_b
);

  //////////////////////////////////////////////////////////////////////////////
  // state
  // the phase machine gates cpu_run only; the divided clocks keep running in
  // every phase, so the clock pin toggles through the reset delay as well
  // hold counts the fuse-picked reset delay, wake counts the restart after sleep

  typedef enum logic [1:0] {
    ST_HOLD = 2'b00, // reset delay counting
    ST_RUN = 2'b01, // clocks running
    ST_WAKE = 2'b10 // wake-up count after sleep
  } scp_phase_t;

  typedef struct packed {
    scp_phase_t phase;
    logic [31:0] dly; // start-up delay counter
    logic [6:0] trim; // trim_value
    logic ce; // divide_change_enable
    logic [2:0] ce_cnt; // cycles since enable
    logic [3:0] code; // requested divide_code
    logic ack; // wishbone ack
    logic err; // wishbone error
    logic [31:0] rdata; // wishbone read data
    logic wake_q; // previous wake level
    logic boot; // first cycle after reset
  } scp_state_t;

  scp_state_t s_r;
  scp_state_t s_nxt;

  // synchroniser for the wake pin; stage one is read only by stage two
  logic wake_s1_r;
  logic wake_s2_r;

  // divider status
  logic div_clk;
  logic [3:0] code_active;
  logic div_settled;
  logic [3:0] reset_code;
  logic [3:0] code_to_div;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // reset delay length picked from the startup fuses
  // counts are in ref_clk cycles, so they scale with the module parameters
  function automatic logic [31:0] startup_len(input logic [1:0] sut);
    unique case (sut)
      scp_pkg::SUT_NONE: startup_len = 32'h0;
      scp_pkg::SUT_SHORT: startup_len = 32'(SHORT_DELAY_CYC);
      scp_pkg::SUT_LONG: startup_len = 32'(LONG_DELAY_CYC);
      default: startup_len = 32'h0; // reserved code: treated as no delay
    endcase
  endfunction

  // reserved codes fall back to the largest legal divider
  function automatic logic [3:0] legal_code(input logic [3:0] c);
    legal_code = (c > scp_pkg::CODE_MAX) ? scp_pkg::CODE_MAX : c;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // wake synchroniser
  // wake pin is asynchronous: two flops before the phase machine looks at it

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wake_s1_r <= 1'b0;
      wake_s2_r <= 1'b0;
    end
    else
    begin
      wake_s1_r <= wake_req;
      wake_s2_r <= wake_s1_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    logic hit;
    logic wr;
    logic [3:0] adr;
    s_nxt = s_r;
    hit = wb_cyc_i && wb_stb_i && !s_r.ack && !s_r.err;
    wr = hit && wb_we_i && wb_sel_i[0];
    adr = wb_adr_i;
    s_nxt.ack = 1'b0;
    s_nxt.err = 1'b0;
    s_nxt.boot = 1'b0;
    s_nxt.wake_q = wake_s2_r;

    // boot cycle: catch trim and the reset delay after release
    if (s_r.boot)
    begin
      s_nxt.trim = factory_trim_valid ? factory_trim : FACTORY_TRIM;
      s_nxt.dly = startup_len(fuses.startup_delay_fuses);
      s_nxt.phase = ST_HOLD;
      // the fuse-picked divide code lands in the register, so readback matches
      // the divider from the first access on
      s_nxt.code = reset_code;
    end
    else
    begin
      // phase machine
      unique case (s_r.phase)
        ST_HOLD:
        begin
          if (s_r.dly == 32'h0)
          begin
            s_nxt.phase = ST_RUN;
          end
          else
          begin
            s_nxt.dly = s_r.dly - 32'h1;
          end
        end
        ST_RUN:
        begin
          // rising wake event starts the six-clock restart
          if (wake_s2_r && !s_r.wake_q)
          begin
            s_nxt.phase = ST_WAKE;
            s_nxt.dly = 32'(scp_pkg::WAKE_CK - 1);
          end
        end
        ST_WAKE:
        begin
          if (s_r.dly == 32'h0)
          begin
            s_nxt.phase = ST_RUN;
          end
          else
          begin
            s_nxt.dly = s_r.dly - 32'h1;
          end
        end
        default: s_nxt.phase = ST_RUN; // illegal code recovers to run
      endcase
    end

    // unlock window ages out after four cycles
    // a fresh enable write in the aging cycle wins: the bus branch below runs last
    if (s_r.ce)
    begin
      if (s_r.ce_cnt == 3'(scp_pkg::UNLOCK_CYCLES - 1))
      begin
        s_nxt.ce = 1'b0;
        s_nxt.ce_cnt = 3'h0;
      end
      else
      begin
        s_nxt.ce_cnt = s_r.ce_cnt + 3'h1;
      end
    end

    // bus access: one-cycle answer
    // hit is masked while ack or err stands, so a master that holds stb for the
    // answer edge is not taken twice
    if (hit)
    begin
      s_nxt.ack = 1'b1;
      s_nxt.rdata = 32'h0;
      unique case (adr)
        scp_pkg::ADDR_TRIM:
        begin
          if (wr)
          begin
            s_nxt.trim = wb_dat_i[scp_pkg::TRIM_MSB:0];
          end
          s_nxt.rdata = {25'h0, s_r.trim}; // bit 7 reads zero
        end
        scp_pkg::ADDR_DIV:
        begin
          if (wr)
          begin
            if (wb_dat_i[scp_pkg::DIV_CE_BIT] && wb_dat_i[6:0] == 7'h0)
            begin
              s_nxt.ce = 1'b1; // open the window, restart its count
              s_nxt.ce_cnt = 3'h0;
            end
            else if (!wb_dat_i[scp_pkg::DIV_CE_BIT] && s_r.ce)
            begin
              // any code, any fuse setting
              s_nxt.code = wb_dat_i[scp_pkg::DIV_CODE_MSB:0];
              s_nxt.ce = 1'b0;
              s_nxt.ce_cnt = 3'h0;
            end
            // otherwise the code is kept as it is
          end
          s_nxt.rdata = {24'h0, s_r.ce, 3'h0, s_r.code};
        end
        scp_pkg::ADDR_STAT:
        begin
          s_nxt.rdata = {24'h0, div_settled, 1'b0, s_r.phase, code_active};
        end
        scp_pkg::ADDR_FUSE:
        begin
          s_nxt.rdata = {24'h0, fuses};
        end
        default:
        begin
          s_nxt.ack = 1'b0; // unmapped address answers with err
          s_nxt.err = 1'b1;
        end
      endcase
    end
  end

  // state register
  // async reset assigns constants only; fuses and the factory byte wait for boot
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_r <= '{phase: ST_HOLD, dly: 32'h0, trim: scp_pkg::TRIM_DEFAULT, ce: 1'b0,
               ce_cnt: 3'h0, code: scp_pkg::CODE_DIV1, ack: 1'b0, err: 1'b0,
               rdata: 32'h0, wake_q: 1'b0, boot: 1'b1};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // divider

  // fuse selects the code the divider starts
  assign reset_code = fuses.divide_by_eight_fuse ? scp_pkg::CODE_DIV8 : scp_pkg::CODE_DIV1;
  // reserved codes are clamped only on the way to the divider; the register
  // still reads back what software wrote
  assign code_to_div = legal_code(s_r.code);
  // the divider swaps codes only at a rising boundary, so this path needs no handshake

  scp_divider #(
    .CODE_W(4),
    .CNT_W(8)
  ) u_div (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .code_in(code_to_div),
    .reset_code(reset_code),
    .clk_out(div_clk),
    .code_active(code_active),
    .settled(div_settled)
  );

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  // external source selected by fuse pattern 0000
  assign ext_clk_sel = (fuses.clock_source_select_fuses == scp_pkg::CLOCK_SOURCE_SELECT_FUSES_EXT);
  assign rc_trim = s_r.trim; // monotonic trim to the oscillator

  // synchronous domains all take the divided clock
  assign clocks.io_clk = div_clk;
  assign clocks.cpu_clk = div_clk;
  assign clocks.flash_clk = div_clk;
  // async timer divided only while clocked synchronously
  assign clocks.async_timer_clock = timer_sync_mode ? div_clk : oscillator_input_pin;

  // interrupts stay blocked exactly while the unlock window is open
  assign irq_block = s_r.ce;
  // cpu held through the reset delay and the six-clock wake
  assign cpu_run = (s_r.phase == ST_RUN) && !s_r.boot;

  // clock out runs during reset too, and carries the divided clock
  // limitation: the pin shows ref_clk itself at divide by one, so it is only as
  // clean as the source clock
  assign portb0_out = div_clk;
  assign portb0_oe_b = ~fuses.clock_output_fuse;

  // bus answers
  assign wb_ack_o = s_r.ack;
  assign wb_err_o = s_r.err;
  assign wb_dat_o = s_r.rdata;

endmodule
`default_nettype wire

//--- test/scp_top_monitor.sv
// checker: bus timing, fuse routing, clock fan-out and unlock window of the prescaler
`timescale 1ns/10ps
`default_nettype none
module scp_top_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // straps and mode
  input wire scp_pkg::scp_fuse_t fuses,
  input wire logic timer_sync_mode,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  // clock side
  input wire scp_pkg::scp_clocks_t clocks,
  input wire logic ext_clk_sel,
  input wire logic irq_block,
  input wire logic portb0_out,
  input wire logic portb0_oe_b
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // a request that is taken but not yet answered
  logic req;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  logic mapped;
  assign mapped = wb_adr_i inside {scp_pkg::ADDR_TRIM, scp_pkg::ADDR_DIV,
                                   scp_pkg::ADDR_STAT, scp_pkg::ADDR_FUSE};
  ////////////////////////////////////////////////////////////////////////////
  ack_answer_a: assert property (req |=> (wb_ack_o != wb_err_o))
    else $error("bus answer missing one cycle after request");
  ack_pulse_a: assert property ((wb_ack_o || wb_err_o) |=> !(wb_ack_o || wb_err_o))
    else $error("bus answer longer than one cycle");
  unmapped_err_a: assert property (req && !mapped |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");
  trim_msb_a: assert property (wb_ack_o && !$past(wb_we_i) &&
    $past(wb_adr_i) == scp_pkg::ADDR_TRIM |-> wb_dat_o[31:7] == 25'h0)
    else $error("trim read shows bits above the field");
  ext_select_a: assert property (ext_clk_sel ==
    (fuses.clock_source_select_fuses == scp_pkg::CLOCK_SOURCE_SELECT_FUSES_EXT))
    else $error("external source select wrong");
  pin_drive_a: assert property (portb0_oe_b == !fuses.clock_output_fuse)
    else $error("clock pin enable wrong");
  pin_clock_a: assert property (portb0_out == clocks.io_clk)
    else $error("clock pin not the divided clock");
  clk_fanout_a: assert property (clocks.cpu_clk == clocks.io_clk &&
    clocks.flash_clk == clocks.io_clk &&
    (!timer_sync_mode || clocks.async_timer_clock == clocks.io_clk))
    else $error("divided clocks disagree");
  window_close_a: assert property ($rose(irq_block) |-> ##[1:5] !irq_block)
    else $error("unlock window stayed open");
  // main scenarios
  cov_err_c: cover property (wb_err_o);
  cov_window_c: cover property ($rose(irq_block));
  cov_read_c: cover property (wb_ack_o && !$past(wb_we_i));
endmodule
bind scp_top scp_top_monitor u_mon (.ref_clk, .rst_b, .fuses, .timer_sync_mode,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
  .clocks, .ext_clk_sel, .irq_block, .portb0_out, .portb0_oe_b);
`default_nettype wire

//--- test/tb_top.sv
// testbench: trim register, fuse defaults, unlock sequence and division factors
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  scp_pkg::scp_fuse_t fuses = '{4'h0, 2'h0, 1'b1, 1'b1};
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, tsync = 1'b1;
  logic wk = 1'b0, osc = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] dat = 32'h0, q;
  logic [31:0] rdat;
  logic ack, err, ecl, irqb, run, pb_out, pb_oe_b, e;
  logic [6:0] trim;
  scp_pkg::scp_clocks_t clks;
  int num_errors = 0, total_checks = 0, cyc_count = 0;
  localparam logic [6:0] FT = 7'h2a; // factory byte seen by the bench
  localparam int SHORT_CYC = 20; // shortened reset delay for simulation
  scp_top #(.SHORT_DELAY_CYC(SHORT_CYC), .LONG_DELAY_CYC(40)) DUT (.ref_clk, .rst_b,
    .oscillator_input_pin(osc), .rc_osc_clk(1'b0), .fuses, .factory_trim(FT),
    .factory_trim_valid(1'b1), .wake_req(wk), .timer_sync_mode(tsync),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .clocks(clks),
    .rc_trim(trim), .ext_clk_sel(ecl), .irq_block(irqb), .cpu_run(run),
    .portb0_out(pb_out), .portb0_oe_b(pb_oe_b));
  ////////////////////////////////////////////////////////////////////////////
  // clock, and a hang guard well above the longest expected run
  initial forever #2 ref_clk = ~ref_clk; // steady source, no frequency steps
  always @(posedge ref_clk)
  begin
    cyc_count++;
    if (cyc_count == 60000)
    begin
      num_errors++;
      final_report();
    end
  end
  task final_report();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // one classic cycle; holds everything until ack or err is sampled high
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'h1;
    // no local limit: only the bench watchdog ends a wait
    do
    begin
      @(posedge ref_clk);
    end
    while (ack !== 1'b1 && err !== 1'b1);
    q = rdat;
    e = err;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  // divided period in ns, after the switch interval has passed
  task period(output logic [31:0] p);
    realtime t0;
    repeat (3) @(posedge clks.io_clk);
    t0 = $realtime;
    @(posedge clks.io_clk);
    p = 32'(int'($realtime - t0));
  endtask
  // enable alone, then the code; nothing is let in between the steps
  task unlock_write(input logic [3:0] code);
    wb(1'b1, scp_pkg::ADDR_DIV, 32'h80);
    #1 check(irqb, 1'b1);
    wb(1'b1, scp_pkg::ADDR_DIV, {28'h0, code});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_reset();
    logic [31:0] p;
    wb(1'b0, scp_pkg::ADDR_TRIM, 32'h0);
    check(q, {25'h0, FT});
    check(ecl, 1'b1);
    wb(1'b0, scp_pkg::ADDR_DIV, 32'h0);
    check(q, 32'h3);
    period(p);
    check(p, 32'd32);
    $display("test reset done");
  endtask
  // no memory writes run here, so the full trim range is fair game
  task t_trim();
    wb(1'b1, scp_pkg::ADDR_TRIM, 32'hff);
    wb(1'b0, scp_pkg::ADDR_TRIM, 32'h0);
    check(q, 32'h7f);
    check(trim, 7'h7f);
    wb(1'b1, scp_pkg::ADDR_TRIM, 32'h00);
    #1 check(trim, 7'h00);
    wb(1'b0, 4'h2, 32'h0);
    check(e, 1'b1);
    $display("test trim done");
  endtask
  task t_locked();
    logic [31:0] p;
    wb(1'b1, scp_pkg::ADDR_DIV, 32'h02);
    period(p);
    check(p, 32'd32);
    $display("test locked done");
  endtask
  task t_codes();
    logic [31:0] p;
    for (int c = 0; c <= 8; c++)
    begin
      unlock_write(4'(c));
      wb(1'b0, scp_pkg::ADDR_DIV, 32'h0);
      check(q, 32'(c));
      period(p);
      check(p, 32'd4 << c);
    end
    $display("test codes done");
  endtask
  task t_expire();
    logic [31:0] p;
    wb(1'b1, scp_pkg::ADDR_DIV, 32'h80);
    repeat (6) @(posedge ref_clk);
    #1 check(irqb, 1'b0);
    wb(1'b1, scp_pkg::ADDR_DIV, 32'h01);
    period(p);
    check(p, 32'd1024);
    $display("test expire done");
  endtask
  // wake edge passes two sync flops, then the cpu waits six clocks
  task t_wake();
    check(run, 1'b1);
    @(posedge ref_clk);
    wk <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 check(run, 1'b0);
    repeat (4) @(posedge ref_clk);
    #1 check(run, 1'b0);
    @(posedge ref_clk);
    #1 check(run, 1'b1);
    @(posedge ref_clk);
    wk <= 1'b0;
    $display("test wake done");
  endtask
  // timer clocked from its own pin is left undivided
  task t_async();
    @(posedge ref_clk);
    tsync <= 1'b0;
    osc <= 1'b1;
    @(posedge ref_clk);
    #1 check(clks.async_timer_clock, 1'b1);
    @(posedge ref_clk);
    osc <= 1'b0;
    @(posedge ref_clk);
    #1 check(clks.async_timer_clock, 1'b0);
    @(posedge ref_clk);
    tsync <= 1'b1;
    $display("test async done");
  endtask
  // second reset with short delay fuse and no divide-by-eight fuse
  task t_restart();
    logic [31:0] p;
    @(posedge ref_clk);
    rst_b <= 1'b0;
    fuses <= '{4'h0, 2'h1, 1'b1, 1'b0};
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (SHORT_CYC + 1) @(posedge ref_clk);
    #1 check(run, 1'b0);
    check(trim, FT);
    @(posedge ref_clk);
    #1 check(run, 1'b1);
    wb(1'b0, scp_pkg::ADDR_DIV, 32'h0);
    check(q, 32'h0);
    period(p);
    check(p, 32'd4);
    $display("test restart done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge ref_clk);
    check(pb_oe_b, 1'b0);
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset();
    t_trim();
    t_locked();
    t_codes();
    t_expire();
    t_wake();
    t_async();
    t_restart();
    final_report();
  end
endmodule
`default_nettype wire
